// file: abd_bus_port.sv
// device end of a multiplexed asynchronous backplane bus: slave, dma master, interrupter
// assumes bus pins arrive through receivers as active-high levels and leave through
// open-collector drivers; the testbench resolves wired lines from the output enables
//
// How it works
// - slave returns status, accepts commands
// - raise dma request when data must move
// - pass dma grant on unless requesting
// - on grant assert select ack, drop request
// - input transfers to tape, output from tape
// - release bus by dropping select ack
// - address with sync, page and write flags
// - input: strobe after address, slave replies
// - input ends: strobe, reply, then sync drop
// - output: data strobe with data, byte flag
// - output ends: reply, strobe, reply, sync drop
// - enabled event raises interrupt request line
// - pass acknowledge unless this device requests
// - defer while higher priority lines request
// - on acknowledge: drop request, reply, vector
// - strobe or acknowledge drop ends vector
// - bus initialize clears the device
// - 22-bit address, 16-bit data
// - data strobe without sync is acknowledge
// - level sets asserted and monitored lines
`timescale 1ns/1ps

module abd_bus_port #(
  parameter int NUM_REGS = 2 // word registers decoded by this device
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // backplane inputs (asynchronous)
  input wire logic [abd_pkg::ADDR_W-1:0] i_mux_addr_data_lines,
  input wire logic i_bus_sync,
  input wire logic i_data_in_strobe,
  input wire logic i_data_out_strobe,
  input wire logic i_slave_reply,
  input wire logic i_write_byte_flag,
  input wire logic i_io_page_select,
  input wire logic i_dma_grant_chain,
  input wire logic i_irq_ack_chain,
  input wire logic i_bus_initialize,
  input wire logic [3:0] i_irq_request_lines,
  // backplane outputs
  output logic [abd_pkg::ADDR_W-1:0] o_mux_addr_data_lines,
  output logic o_mux_addr_data_lines_oe,
  output logic o_bus_sync,
  output logic o_data_in_strobe,
  output logic o_data_out_strobe,
  output logic o_slave_reply,
  output logic o_write_byte_flag,
  output logic o_io_page_select,
  output logic o_dma_request_line,
  output logic o_select_acknowledge,
  output logic o_dma_grant_out,
  output logic o_irq_ack_out,
  output logic [3:0] o_irq_request_lines,
  // user side: configuration straps
  input wire logic [abd_pkg::ADDR_W-1:0] i_base_addr,
  input wire logic [abd_pkg::DATA_W-1:0] i_vector,
  input wire logic [1:0] i_irq_level,
  // user side: register access
  input wire logic [abd_pkg::DATA_W-1:0] i_reg_rdata,
  output logic [abd_pkg::REG_BASE_LSB-abd_pkg::REG_IDX_LSB-1:0] o_reg_idx,
  output logic o_reg_wr,
  output logic o_reg_byte,
  output logic [abd_pkg::DATA_W-1:0] o_reg_wdata,
  // user side: dma request
  input wire logic i_dma_start,
  input wire logic i_dma_to_mem,
  input wire logic i_dma_byte,
  input wire logic [abd_pkg::ADDR_W-1:0] i_dma_addr,
  input wire logic [abd_pkg::DATA_W-1:0] i_dma_wdata,
  output logic o_dma_busy,
  output logic o_dma_done,
  output logic [abd_pkg::DATA_W-1:0] o_dma_rdata,
  // user side: interrupt
  input wire logic i_irq_enable,
  input wire logic i_irq_event
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [abd_pkg::SY_W-1:0] sy_meta; // first stage, read only by the second
  logic [abd_pkg::SY_W-1:0] sy; // usable control levels
  logic [abd_pkg::ADDR_W-1:0] dal_meta; // first stage of the data lines
  logic [abd_pkg::ADDR_W-1:0] dal; // usable data lines
  logic [abd_pkg::SY_W-1:0] sy_raw;

  assign sy_raw = {i_irq_request_lines, i_bus_initialize, i_irq_ack_chain, i_dma_grant_chain,
                   i_io_page_select, i_write_byte_flag, i_slave_reply, i_data_out_strobe,
                   i_data_in_strobe, i_bus_sync};

  // two flops per pin; data lines settle before the strobes they ride with
  always_ff @(posedge i_ref_clk)
  begin
    sy_meta <= sy_raw;
    sy <= sy_meta;
    dal_meta <= i_mux_addr_data_lines;
    dal <= dal_meta;
  end

  logic s_sync, s_din, s_dout, s_rply, s_grant, s_iak, s_init, s_bs7, s_wtbt;
  logic [3:0] s_irq;
  assign s_sync = sy[abd_pkg::SY_SYNC];
  assign s_din = sy[abd_pkg::SY_DIN];
  assign s_dout = sy[abd_pkg::SY_DOUT];
  assign s_rply = sy[abd_pkg::SY_RPLY];
  assign s_wtbt = sy[abd_pkg::SY_WTBT];
  assign s_bs7 = sy[abd_pkg::SY_BS7];
  assign s_grant = sy[abd_pkg::SY_GRANT];
  assign s_iak = sy[abd_pkg::SY_IAK];
  assign s_init = sy[abd_pkg::SY_INIT];
  assign s_irq = sy[abd_pkg::SY_IRQ +: 4];

  // bus initialize acts like the local reset
  logic clr;
  assign clr = !i_rst_n || s_init;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt priority mapping

  logic [3:0] irq_drive; // lines asserted at the chosen level
  logic [3:0] irq_watch; // higher lines that block the claim
  always_comb
  begin
    case (i_irq_level)
      2'h0:
      begin
        irq_drive = 4'h1;
        irq_watch = 4'h6;
      end
      2'h1:
      begin
        irq_drive = 4'h3;
        irq_watch = 4'h4;
      end
      2'h2:
      begin
        irq_drive = 4'h5;
        irq_watch = 4'h8;
      end
      default:
      begin
        irq_drive = 4'hd;
        irq_watch = 4'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state

  abd_pkg::abd_state_t state, next_state;
  logic [abd_pkg::CNT_W-1:0] cnt, next_cnt; // setup and hold timer
  logic sync_prev, next_sync_prev; // edge detect on synchronised sync
  logic irq_pend, next_irq_pend; // interrupt waiting for service
  logic dma_pend, next_dma_pend; // dma transfer waiting
  logic dma_dir, next_dma_dir; // 1: store to memory
  logic dma_byte, next_dma_byte;
  logic [abd_pkg::ADDR_W-1:0] dma_addr, next_dma_addr;
  logic [abd_pkg::DATA_W-1:0] dma_wdata, next_dma_wdata;
  logic [abd_pkg::DATA_W-1:0] dma_rdata, next_dma_rdata;
  logic dma_done, next_dma_done;
  logic [abd_pkg::ADDR_W-1:0] lat_addr, next_lat_addr; // latched slave address
  logic [abd_pkg::ADDR_W-1:0] dal_out, next_dal_out;
  logic dal_oe, next_dal_oe;
  logic sync_o, next_sync_o, din_o, next_din_o, dout_o, next_dout_o;
  logic wtbt_o, next_wtbt_o, bs7_o, next_bs7_o, rply_o, next_rply_o;
  logic dmr_o, next_dmr_o, select_ack_short_o, next_select_ack_short_o;
  logic reg_wr, next_reg_wr, reg_byte, next_reg_byte;
  logic [abd_pkg::DATA_W-1:0] reg_wdata, next_reg_wdata;

  // own registers: i/o page address whose upper bits match the base
  logic addr_hit;
  assign addr_hit = s_bs7 && (dal[abd_pkg::ADDR_W-1:abd_pkg::REG_BASE_LSB]
                    == i_base_addr[abd_pkg::ADDR_W-1:abd_pkg::REG_BASE_LSB]);
  logic io_page;
  // from the job latched at start, so a new start cannot change the page flag mid-cycle
  assign io_page = &dma_addr[abd_pkg::ADDR_W-1:abd_pkg::IO_PAGE_LSB];

  // next-state logic for the whole bus port
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_sync_prev = s_sync;
    next_irq_pend = irq_pend;
    next_dma_pend = dma_pend;
    next_dma_dir = dma_dir;
    next_dma_byte = dma_byte;
    next_dma_addr = dma_addr;
    next_dma_wdata = dma_wdata;
    next_dma_rdata = dma_rdata;
    next_dma_done = 1'b0;
    next_lat_addr = lat_addr;
    next_dal_out = dal_out;
    next_dal_oe = dal_oe;
    next_sync_o = sync_o;
    next_din_o = din_o;
    next_dout_o = dout_o;
    next_wtbt_o = wtbt_o;
    next_bs7_o = bs7_o;
    next_rply_o = rply_o;
    next_dmr_o = dmr_o;
    next_select_ack_short_o = select_ack_short_o;
    next_reg_wr = 1'b0;
    next_reg_byte = reg_byte;
    next_reg_wdata = reg_wdata;
    // accept a new dma job only while none is queued
    if (i_dma_start && !dma_pend)
    begin
      next_dma_pend = 1'b1;
      next_dma_dir = i_dma_to_mem;
      next_dma_byte = i_dma_byte;
      next_dma_addr = i_dma_addr;
      next_dma_wdata = i_dma_wdata;
    end
    // interrupt drops when disabled; an event while enabled wins over the claim
    if (!i_irq_enable)
      next_irq_pend = 1'b0;
    case (state)
      abd_pkg::ST_IDLE:
      begin
        if (s_sync && !sync_prev && addr_hit)
        begin
          next_lat_addr = dal;
          next_state = abd_pkg::ST_SL_SEL;
        end
        else if (s_din && !s_sync && s_iak && irq_pend && !(|(s_irq & irq_watch)))
        begin
          next_irq_pend = 1'b0;
          next_rply_o = 1'b1;
          next_dal_out = {{(abd_pkg::ADDR_W-abd_pkg::DATA_W){1'b0}}, i_vector};
          next_dal_oe = 1'b1;
          next_state = abd_pkg::ST_IAK;
        end
        else if (dma_pend && !s_sync)
        begin
          next_dmr_o = 1'b1;
          next_state = abd_pkg::ST_DMA_REQ;
        end
      end
      abd_pkg::ST_SL_SEL:
      begin
        // address gone, wait for the strobe that decides direction
        if (!s_sync)
          next_state = abd_pkg::ST_IDLE;
        else if (s_din)
        begin
          next_dal_out = {{(abd_pkg::ADDR_W-abd_pkg::DATA_W){1'b0}}, i_reg_rdata};
          next_dal_oe = 1'b1;
          next_rply_o = 1'b1;
          next_state = abd_pkg::ST_SL_END;
        end
        else if (s_dout)
        begin
          next_reg_wdata = dal[abd_pkg::DATA_W-1:0];
          next_reg_byte = s_wtbt;
          next_reg_wr = 1'b1;
          next_rply_o = 1'b1;
          next_state = abd_pkg::ST_SL_END;
        end
      end
      abd_pkg::ST_SL_END:
      begin
        // master dropped its strobe: remove reply and data
        if (!s_din && !s_dout)
        begin
          next_rply_o = 1'b0;
          next_dal_oe = 1'b0;
          next_state = abd_pkg::ST_IDLE;
        end
      end
      abd_pkg::ST_IAK:
      begin
        if (!s_din || !s_iak)
        begin
          next_rply_o = 1'b0;
          next_dal_oe = 1'b0;
          next_state = abd_pkg::ST_IDLE;
        end
      end
      abd_pkg::ST_DMA_REQ:
      begin
        // processor finishes its cycle before granting
        if (s_grant)
        begin
          next_select_ack_short_o = 1'b1;
          next_dmr_o = 1'b0;
          next_state = abd_pkg::ST_DMA_GNT;
        end
      end
      abd_pkg::ST_DMA_GNT:
      begin
        // master once grant negated and the previous cycle is over
        if (!s_grant && !s_sync && !s_rply)
        begin
          next_dal_out = dma_addr;
          next_dal_oe = 1'b1;
          next_bs7_o = io_page;
          next_wtbt_o = dma_dir;
          next_cnt = abd_pkg::CNT_W'(abd_pkg::ADDR_SETUP_CYC);
          next_state = abd_pkg::ST_M_ADDR;
        end
      end
      abd_pkg::ST_M_ADDR:
      begin
        if (cnt <= abd_pkg::CNT_W'(1))
        begin
          next_sync_o = 1'b1;
          next_cnt = abd_pkg::CNT_W'(abd_pkg::ADDR_HOLD_CYC);
          next_state = abd_pkg::ST_M_HOLD;
        end
        else
          next_cnt = cnt - abd_pkg::CNT_W'(1);
      end
      abd_pkg::ST_M_HOLD:
      begin
        if (cnt <= abd_pkg::CNT_W'(1))
        begin
          next_bs7_o = 1'b0;
          if (dma_dir)
          begin
            next_dal_out = {{(abd_pkg::ADDR_W-abd_pkg::DATA_W){1'b0}}, dma_wdata};
            next_dout_o = 1'b1;
            next_wtbt_o = dma_byte;
          end
          else
          begin
            next_dal_oe = 1'b0;
            next_din_o = 1'b1;
            next_wtbt_o = 1'b0;
          end
          next_state = abd_pkg::ST_M_DATA;
        end
        else
          next_cnt = cnt - abd_pkg::CNT_W'(1);
      end
      abd_pkg::ST_M_DATA:
      begin
        if (s_rply)
        begin
          if (!dma_dir)
            next_dma_rdata = dal[abd_pkg::DATA_W-1:0];
          next_din_o = 1'b0;
          next_dout_o = 1'b0;
          next_wtbt_o = 1'b0;
          next_dal_oe = 1'b0;
          next_state = abd_pkg::ST_M_TERM;
        end
      end
      abd_pkg::ST_M_TERM:
      begin
        if (!s_rply)
        begin
          next_sync_o = 1'b0;
          next_select_ack_short_o = 1'b0;
          next_dma_pend = 1'b0;
          next_dma_done = 1'b1;
          next_state = abd_pkg::ST_IDLE;
        end
      end
      default:
        next_state = abd_pkg::ST_IDLE;
    endcase
    if (i_irq_enable && i_irq_event)
      next_irq_pend = 1'b1;
  end

  // state registers; initialize from the bus clears everything
  always_ff @(posedge i_ref_clk)
  begin
    if (clr)
    begin
      state <= abd_pkg::ST_IDLE;
      cnt <= '0;
      sync_prev <= 1'b0;
      irq_pend <= 1'b0;
      dma_pend <= 1'b0;
      dma_dir <= 1'b0;
      dma_byte <= 1'b0;
      dma_addr <= '0;
      dma_wdata <= '0;
      dma_rdata <= '0;
      dma_done <= 1'b0;
      lat_addr <= '0;
      dal_out <= '0;
      dal_oe <= 1'b0;
      sync_o <= 1'b0;
      din_o <= 1'b0;
      dout_o <= 1'b0;
      wtbt_o <= 1'b0;
      bs7_o <= 1'b0;
      rply_o <= 1'b0;
      dmr_o <= 1'b0;
      select_ack_short_o <= 1'b0;
      reg_wr <= 1'b0;
      reg_byte <= 1'b0;
      reg_wdata <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      sync_prev <= next_sync_prev;
      irq_pend <= next_irq_pend;
      dma_pend <= next_dma_pend;
      dma_dir <= next_dma_dir;
      dma_byte <= next_dma_byte;
      dma_addr <= next_dma_addr;
      dma_wdata <= next_dma_wdata;
      dma_rdata <= next_dma_rdata;
      dma_done <= next_dma_done;
      lat_addr <= next_lat_addr;
      dal_out <= next_dal_out;
      dal_oe <= next_dal_oe;
      sync_o <= next_sync_o;
      din_o <= next_din_o;
      dout_o <= next_dout_o;
      wtbt_o <= next_wtbt_o;
      bs7_o <= next_bs7_o;
      rply_o <= next_rply_o;
      dmr_o <= next_dmr_o;
      select_ack_short_o <= next_select_ack_short_o;
      reg_wr <= next_reg_wr;
      reg_byte <= next_reg_byte;
      reg_wdata <= next_reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_mux_addr_data_lines = dal_out;
  assign o_mux_addr_data_lines_oe = dal_oe;
  assign o_bus_sync = sync_o;
  assign o_data_in_strobe = din_o;
  assign o_data_out_strobe = dout_o;
  assign o_slave_reply = rply_o;
  assign o_write_byte_flag = wtbt_o;
  assign o_io_page_select = bs7_o;
  assign o_dma_request_line = dmr_o;
  assign o_select_acknowledge = select_ack_short_o;
  // chains pass on unless this device holds a request of its own
  assign o_dma_grant_out = s_grant && !dma_pend;
  assign o_irq_ack_out = s_iak && !irq_pend && (state != abd_pkg::ST_IAK);
  assign o_irq_request_lines = irq_pend ? irq_drive : 4'h0;
  assign o_reg_idx = lat_addr[abd_pkg::REG_BASE_LSB-1:abd_pkg::REG_IDX_LSB];
  assign o_reg_wr = reg_wr;
  assign o_reg_byte = reg_byte;
  assign o_reg_wdata = reg_wdata;
  assign o_dma_busy = dma_pend;
  assign o_dma_done = dma_done;
  assign o_dma_rdata = dma_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (clr);

  sequence grant_taken;
    state == abd_pkg::ST_DMA_REQ && s_grant;
  endsequence

  a_grant_select_ack_short: assert property (grant_taken |=> select_ack_short_o && !dmr_o)
    else $error("grant not acknowledged");
  a_grant_keep: assert property (dma_pend |-> !o_dma_grant_out)
    else $error("grant passed while requesting");
  a_select_ack_short_release: assert property ($fell(select_ack_short_o) |-> $past(state) == abd_pkg::ST_M_TERM && !sync_o)
    else $error("bus released out of order");
  a_sync_addr: assert property ($rose(sync_o) |-> dal_oe && $past(dal_oe, 2))
    else $error("sync without address");
  a_strobe_sync: assert property ((din_o || dout_o) |-> sync_o && select_ack_short_o)
    else $error("strobe outside master cycle");
  a_reply_drop: assert property (state == abd_pkg::ST_SL_END && !s_din && !s_dout |=> !rply_o)
    else $error("reply held after strobe");
  a_iak_claim: assert property ($rose(rply_o) && $past(state) == abd_pkg::ST_IDLE
    |-> !irq_pend && o_irq_request_lines == 4'h0 && dal_out[abd_pkg::DATA_W-1:0] == i_vector)
    else $error("vector claim wrong");
  a_iak_block: assert property (state == abd_pkg::ST_IDLE && (|(s_irq & irq_watch)) && !(s_sync && !sync_prev)
    |=> state != abd_pkg::ST_IAK)
    else $error("claimed over higher priority");
  a_irq_event: assert property (i_irq_enable && i_irq_event |=> irq_pend)
    else $error("event lost");

endmodule // abd_bus_port

// file: abd_pkg.sv
// shared constants and state encoding for the backplane bus port
// assumes a single 125 MHz clock; all bus pins are seen as active-high logic levels
package abd_pkg;

  // bus widths: address uses all lines, data only the low part
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;

  // clock period in picoseconds (125 MHz)
  localparam int CLK_PS = 8000;

  // master address setup before bus_sync, and hold of address after bus_sync
  localparam int ADDR_SETUP_NS = 150;
  localparam int ADDR_HOLD_NS = 100;
  // least times round up to whole cycles
  localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W = 5;

  // i/o page: the top address bits all set
  localparam int IO_PAGE_LSB = 13;
  // register decode: word registers, two of them per device
  localparam int REG_IDX_LSB = 1;
  localparam int REG_BASE_LSB = 2;

  // index of each synchronised control input inside the sync vector
  localparam int SY_SYNC = 0;
  localparam int SY_DIN = 1;
  localparam int SY_DOUT = 2;
  localparam int SY_RPLY = 3;
  localparam int SY_WTBT = 4;
  localparam int SY_BS7 = 5;
  localparam int SY_GRANT = 6;
  localparam int SY_IAK = 7;
  localparam int SY_INIT = 8;
  localparam int SY_IRQ = 9;
  localparam int SY_W = 13;

  // bus port sequencer states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_SL_SEL = 10'h002,
    ST_SL_END = 10'h004,
    ST_IAK = 10'h008,
    ST_DMA_REQ = 10'h010,
    ST_DMA_GNT = 10'h020,
    ST_M_ADDR = 10'h040,
    ST_M_HOLD = 10'h080,
    ST_M_DATA = 10'h100,
    ST_M_TERM = 10'h200
  } abd_state_t;

endpackage

// file: abd_host_mem.sv
// host model for the bus port bench: dma grant source and memory slave
// assumes wired active-high levels resolved by the testbench; released lines read 0
`timescale 1ns/1ps

module abd_host_mem (
  input wire logic i_clk,
  input wire logic i_sync,
  input wire logic i_din,
  input wire logic i_dout,
  input wire logic i_wtbt,
  input wire logic i_req,
  input wire logic i_select_ack_short,
  input wire logic [3:0] i_lat,
  input wire logic [15:0] i_word,
  input wire logic [21:0] i_lines,
  output logic o_gnt,
  output logic o_reply,
  output logic o_oe,
  output logic [21:0] o_data,
  output logic [21:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_wbyte
);
  logic sync_q; // last sync level, finds its rise
  logic [3:0] cnt; // answer delay, lets the bench be slow or prompt

  // everything idle at time zero
  initial
  begin
    {o_gnt, o_reply, o_oe, sync_q, o_wbyte} = 5'h00;
    {o_data, o_addr, o_wdata, cnt} = 64'h0;
  end

  //////////////////////////////////////////////////
  // grant, address latch and memory answer
  always @(posedge i_clk)
  begin
    sync_q <= i_sync;
    // grant only between cycles, withdrawn once selected
    if (i_select_ack_short)
      o_gnt <= 1'b0;
    else if (i_req && !i_sync)
      o_gnt <= 1'b1;
    // memory keeps the address given with sync
    if (i_sync && !sync_q && i_select_ack_short)
      o_addr <= i_lines;
    if (i_select_ack_short && (i_din || i_dout) && !o_reply)
    begin
      cnt <= cnt + 4'h1;
      if (cnt >= i_lat)
      begin
        o_reply <= 1'b1;
        o_oe <= i_din;
        o_data <= {6'h00, i_word};
        o_wdata <= i_lines[15:0];
        o_wbyte <= i_wtbt;
      end
    end
    else if (!i_din && !i_dout)
    begin
      // strobe gone: reply and data leave the bus
      cnt <= 4'h0;
      o_reply <= 1'b0;
      o_oe <= 1'b0;
    end
  end
endmodule // abd_host_mem

// file: tb_top.sv
// self-checking bench for the bus port: processor cycles, dma, interrupts
// assumes the host model answers memory cycles; the bench plays the processor
`timescale 1ns/1ps

module tb_top;
  logic clk, rst_n, h_oe, h_sync, h_din, h_dout, h_wtbt, h_bs7, h_iak, h_init, tb_gnt;
  logic [21:0] h_data, base, daddr;
  logic [3:0] h_irq, lat;
  logic [15:0] vec, dwd, mword, rd, rwd, drd, p_wdata;
  logic [1:0] lvl;
  logic start, to_mem, dbyte, irq_en, irq_ev, ddone, rwr, rbyte, done_seen, wr_seen, wr_byte;
  logic dbusy, m_bs7, m_wtbt; // dma busy, address-phase page and write flags
  logic [0:0] ridx, wr_idx;
  logic [15:0] wr_data;
  logic d_oe, d_sync, d_din, d_dout, d_rply, d_wtbt, d_bs7, d_req, d_select_ack_short, d_gout, d_aout;
  logic [21:0] d_lines, p_data, p_addr;
  logic [3:0] d_irq;
  logic p_gnt, p_rply, p_oe, p_wbyte;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // wired bus: whoever enables drives, released lines read 0
  wire logic [21:0] bus = d_oe ? d_lines : (h_oe ? h_data : (p_oe ? p_data : 22'h000000));
  wire logic w_sync = d_sync | h_sync;
  wire logic w_din = d_din | h_din;
  wire logic w_dout = d_dout | h_dout;
  wire logic w_wtbt = d_wtbt | h_wtbt;
  wire logic w_bs7 = d_bs7 | h_bs7;
  wire logic w_rply = d_rply | p_rply;
  wire logic w_gnt = p_gnt | tb_gnt;
  wire logic [3:0] w_irq = d_irq | h_irq;
  // status per word index, changes with the index so decode is seen
  wire logic [15:0] rdata = ridx[0] ? 16'hbeef : 16'h1234;

  abd_bus_port i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_mux_addr_data_lines(bus),
    .i_bus_sync(w_sync), .i_data_in_strobe(w_din), .i_data_out_strobe(w_dout),
    .i_slave_reply(w_rply), .i_write_byte_flag(w_wtbt), .i_io_page_select(w_bs7),
    .i_dma_grant_chain(w_gnt), .i_irq_ack_chain(h_iak), .i_bus_initialize(h_init),
    .i_irq_request_lines(w_irq), .o_mux_addr_data_lines(d_lines), .o_mux_addr_data_lines_oe(d_oe),
    .o_bus_sync(d_sync), .o_data_in_strobe(d_din), .o_data_out_strobe(d_dout), .o_slave_reply(d_rply),
    .o_write_byte_flag(d_wtbt), .o_io_page_select(d_bs7), .o_dma_request_line(d_req),
    .o_select_acknowledge(d_select_ack_short), .o_dma_grant_out(d_gout), .o_irq_ack_out(d_aout),
    .o_irq_request_lines(d_irq), .i_base_addr(base), .i_vector(vec), .i_irq_level(lvl),
    .i_reg_rdata(rdata), .o_reg_idx(ridx), .o_reg_wr(rwr), .o_reg_byte(rbyte), .o_reg_wdata(rwd),
    .i_dma_start(start), .i_dma_to_mem(to_mem), .i_dma_byte(dbyte), .i_dma_addr(daddr),
    .i_dma_wdata(dwd), .o_dma_busy(dbusy), .o_dma_done(ddone), .o_dma_rdata(drd),
    .i_irq_enable(irq_en), .i_irq_event(irq_ev));

  abd_host_mem i_host (.i_clk(clk), .i_sync(w_sync), .i_din(w_din), .i_dout(w_dout),
    .i_wtbt(w_wtbt), .i_req(d_req), .i_select_ack_short(d_select_ack_short), .i_lat(lat), .i_word(mword), .i_lines(bus),
    .o_gnt(p_gnt), .o_reply(p_rply), .o_oe(p_oe), .o_data(p_data), .o_addr(p_addr),
    .o_wdata(p_wdata), .o_wbyte(p_wbyte));

  //////////////////////////////////////////////////
  // clock, pulse catchers and hang limit
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // one-cycle pulses are caught here so tasks cannot miss them
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (rwr)
      {wr_seen, wr_idx, wr_byte, wr_data} <= {1'b1, ridx, rbyte, rwd};
    if (ddone)
      done_seen <= 1'b1;
    // address phase of an own master cycle: sync with the address still driven
    if (d_sync && d_oe && !d_dout)
      {m_bs7, m_wtbt} <= {d_bs7, d_wtbt};
    if (cycles == 6000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // processor cycle to the device; request held until reply is sampled
  task automatic proc_cycle(input logic [21:0] a, input logic wr, input logic byt, input logic [15:0] wd);
    {h_data, h_oe, h_bs7, h_wtbt} = {a, 1'b1, 1'b1, wr};
    tick(2);
    h_sync = 1'b1;
    tick(3);
    {h_data, h_oe, h_wtbt, h_din, h_dout} = {6'h00, wd, wr, byt, !wr, wr};
    for (int i = 0; i < 40 && w_rply !== 1'b1; i++) tick(1);
    rd = bus[15:0];
    {h_din, h_dout, h_oe, h_wtbt} = 4'h0;
    for (int i = 0; i < 40 && w_rply !== 1'b0; i++) tick(1);
    {h_sync, h_bs7} = 2'b00;
    tick(2);
  endtask

  //////////////////////////////////////////////////
  // scenarios
  task automatic t_slave;
    wr_seen = 1'b0;
    proc_cycle(base + 22'h2, 1'b1, 1'b1, 16'ha55a);
    chk("reg write", {3'h0, 3'h7, 16'ha55a}, {3'h0, wr_seen, wr_idx, wr_byte, wr_data});
    proc_cycle(base + 22'h2, 1'b0, 1'b0, 16'h0000);
    chk("reg read", {6'h00, 16'hbeef}, {6'h00, rd});
    chk("reply off", 22'h0, {21'h0, d_rply});
    wr_seen = 1'b0;
    proc_cycle(base + 22'h10, 1'b1, 1'b0, 16'h0f0f);
    chk("foreign addr", 22'h0, {21'h0, wr_seen});
    $display("test slave done");
  endtask

  task automatic t_dma(input logic tm, input logic byt, input logic [3:0] l, input logic [21:0] a, input logic pg);
    {done_seen, to_mem, dbyte, lat, daddr, dwd, mword} = {1'b0, tm, byt, l, a, 16'h5a3c, 16'hc3c3};
    {m_bs7, m_wtbt} = {!pg, !tm};
    start = 1'b1;
    tick(1);
    start = 1'b0;
    chk("dma busy", 22'h1, {21'h0, dbusy});
    for (int i = 0; i < 300 && done_seen !== 1'b1; i++) tick(1);
    chk("dma done", 22'h1, {21'h0, done_seen});
    chk("dma addr", a, p_addr);
    chk("dma flags", {20'h0, pg, tm}, {20'h0, m_bs7, m_wtbt});
    if (tm)
      chk("dma store", {5'h00, byt, 16'h5a3c}, {5'h00, p_wbyte, p_wdata});
    else
      chk("dma fetch", {6'h00, 16'hc3c3}, {6'h00, drd});
    chk("bus freed", 22'h0, {18'h0, dbusy, d_select_ack_short, d_req, d_oe});
    $display("test dma done");
  endtask

  task automatic t_irq;
    logic [3:0] lines [4] = '{4'h1, 4'h3, 4'h5, 4'hd};
    for (int l = 0; l < 4; l++)
    begin
      {lvl, irq_en, irq_ev} = {2'(l), 2'b11};
      tick(1);
      irq_ev = 1'b0;
      tick(2);
      chk("irq lines", {18'h0, lines[l]}, {18'h0, d_irq});
      irq_en = 1'b0;
      tick(2);
    end
    {lvl, irq_en, irq_ev} = 4'h7;
    tick(1);
    {irq_ev, h_irq, h_din, h_iak} = {1'b0, 4'h4, 2'b11};
    tick(8);
    chk("held off", 22'h0, {20'h0, d_rply, d_aout});
    h_irq = 4'h0;
    for (int i = 0; i < 40 && w_rply !== 1'b1; i++) tick(1);
    chk("vector", {6'h00, vec}, bus);
    chk("irq withdrawn", 22'h0, {18'h0, d_irq});
    {h_din, h_iak} = 2'b00;
    for (int i = 0; i < 40 && w_rply !== 1'b0; i++) tick(1);
    tick(1);
    chk("vector off", 22'h0, {20'h0, d_rply, d_oe});
    h_iak = 1'b1;
    tick(4);
    chk("ack passed", 22'h1, {21'h0, d_aout});
    h_iak = 1'b0;
    tick(2);
    $display("test irq done");
  endtask

  task automatic t_misc;
    tb_gnt = 1'b1;
    tick(4);
    chk("grant passed", 22'h1, {21'h0, d_gout});
    tb_gnt = 1'b0;
    {irq_ev, h_init} = 2'b10;
    tick(1);
    {irq_ev, h_init} = 2'b01;
    tick(4);
    chk("init clears", 22'h0, {18'h0, d_irq});
    {h_init, irq_en} = 2'b00;
    tick(3);
    $display("test misc done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  //////////////////////////////////////////////////
  // main sequence: reset, then each scenario in turn
  initial
  begin
    {rst_n, h_oe, h_sync, h_din, h_dout, h_wtbt, h_bs7, h_iak, h_init, tb_gnt} = 10'h000;
    {h_data, daddr, h_irq, lat, dwd, mword, lvl} = 72'h0;
    {start, to_mem, dbyte, irq_en, irq_ev, done_seen, wr_seen} = 7'h00;
    base = 22'h3ff550;
    vec = 16'h00a4;
    tick(10);
    rst_n = 1'b1;
    tick(1);
    chk("after reset", 22'h0, {13'h0, d_oe, d_sync, d_rply, d_req, d_select_ack_short, d_irq});
    t_slave();
    t_dma(1'b0, 1'b0, 4'h0, 22'h001230, 1'b0);
    t_dma(1'b1, 1'b1, 4'h6, 22'h3fe010, 1'b1);
    t_irq();
    t_misc();
    tally_and_finish();
  end
endmodule // tb_top
